//--- common/hcp_pkg.sv
// Shared constants and types for the host command and test port
package hcp_pkg;

  // Two-port register word addresses
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_ERR = 2'h1;
  localparam logic [1:0] ADDR_P1  = 2'h2;
  localparam logic [1:0] ADDR_P2  = 2'h3;

  // Command register bit positions, control layout
  localparam int BIT_TEST      = 15;
  localparam int BIT_HARD_RESET = 14;
  localparam int BIT_IDENTIFY  = 10;
  localparam int BIT_SHM_OFF   = 8;
  localparam int BIT_SHM_SHOW  = 7;
  localparam int BIT_SHM_ON    = 6;
  localparam int BIT_CONFIG    = 4;
  localparam int BIT_DEBUG     = 3;
  localparam int BIT_RESTART   = 2;
  localparam int BIT_DMA       = 1;
  localparam int BIT_TRAP      = 0;

  // Debug layout exit bits
  localparam int DBG_EXIT      = 15;
  localparam int DBG_PROCEED   = 4;
  localparam int DBG_GO        = 3;

  // Error register bits
  localparam int ERR_CMD       = 15;
  localparam int ERR_DMA       = 14;

  // Field layouts
  localparam int SEL_W          = 11;
  localparam int SHM_BASE_W     = 10;
  localparam int CFG_SWITCH_LSB = 4;
  localparam int CFG_ROM_LSB    = 1;
  localparam logic [15:0] RESTART_USE_SWITCH = 16'h0008;

  // Reset values
  localparam logic [15:0] CMD_RESET   = 16'h0000;
  localparam logic [15:0] ERR_RESET   = 16'h0000;
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef enum logic [1:0] {
    ENG_TEST,
    ENG_DMA,
    ENG_TRAP,
    ENG_RESTART
  } eng_kind_t;

  typedef struct packed {
    logic             start;
    eng_kind_t        kind;
    logic [SEL_W-1:0] sel;
    logic [15:0]      arg_a;
    logic [15:0]      arg_b;
  } eng_req_t;

endpackage

//--- hw/onehot_check.sv
// Flags a vector with exactly one bit set
`timescale 1ns/10ps
module onehot_check #(
  parameter int W = 11
) (
  // Vector under test
  input  wire logic [W-1:0] vec,
  // Result
  output logic              one
);

  always_comb begin
    one = (vec != '0) && ((vec & (vec - W'(1))) == '0);
  end

endmodule // onehot_check

//--- hw/param_reg.sv
// Two-port parameter word, local load wins over host write
`timescale 1ns/10ps
module param_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Host side
  input  wire logic        host_we,
  input  wire logic [15:0] host_d,
  // Local side
  input  wire logic        load,
  input  wire logic [15:0] load_d,
  // Contents
  output logic [15:0]      q
);

  logic [15:0] next_q;

  // Device results must not be lost to a colliding host write
  always_comb begin
    next_q = q;
    if (load) begin
      next_q = load_d;
    end else if (host_we) begin
      next_q = host_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= RESET_VAL;
    end else begin
      q <= next_q;
    end
  end

endmodule // param_reg

//--- hw/host_command_test_port.sv
// Host command and test register interpreter of the two-port file
`timescale 1ns/10ps
module host_command_test_port
  import hcp_pkg::*;
#(
  parameter logic [15:0] BOARD_ID = 16'h00a5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_B,
  // Host port of the register file
  input  wire host_req_t        HOST_REQ,
  output logic [15:0]           HOST_RDATA,
  // Local power-up request, same cycle as the write
  output logic                  LOCAL_POWERUP,
  // Board straps
  input  wire logic [3:0]       BOOT_SWITCH,
  input  wire logic [1:0]       ROM_SIZE,
  // Long-running operation engine
  output eng_req_t              ENG_REQ,
  input  wire logic             ENG_DONE,
  input  wire logic             ENG_FAIL,
  input  wire logic [15:0]      ENG_DATA,
  // Local firmware clear of the error word
  input  wire logic             ERR_CLEAR,
  // Shared memory and mode state
  output logic                  SHM_ENABLE,
  output logic [SHM_BASE_W-1:0] SHM_BASE,
  output logic [15:0]           SHM_BLOCKS,
  output logic                  DEBUG_MODE,
  output logic                  UPPER_CLEAR
);

  typedef enum {ST_IDLE, ST_EXEC, ST_DEBUG} state_t;

  state_t                state, next_state;
  logic [15:0]           cmd, next_cmd;
  logic [15:0]           err, next_err;
  logic                  shm_en, next_shm_en;
  logic [SHM_BASE_W-1:0] shm_base, next_shm_base;
  logic [15:0]           shm_blocks, next_shm_blocks;
  eng_req_t              eng_req, next_eng_req;
  logic [15:0]           rdata, next_rdata;
  logic                  upper_clear, next_upper_clear;
  logic [15:0]           p1, p2, p1_val, p2_val;
  logic                  p1_load, p2_load, p1_we, p2_we;
  logic                  host_cmd_wr, hard_reset, sel_one;
  logic                  set_cmd_err, set_dma;
  logic [15:0]           wd;

  assign wd          = HOST_REQ.wdata;
  assign host_cmd_wr = HOST_REQ.wr && (HOST_REQ.addr == ADDR_CMD);
  // No gating: must act even with firmware or enables missing
  assign hard_reset  = host_cmd_wr && wd[BIT_HARD_RESET];
  assign p1_we = HOST_REQ.wr && (HOST_REQ.addr == ADDR_P1) && !hard_reset;
  assign p2_we = HOST_REQ.wr && (HOST_REQ.addr == ADDR_P2) && !hard_reset;

  onehot_check #(.W(SEL_W)) u_sel_check (
    .vec (wd[SEL_W-1:0]),
    .one (sel_one)
  );

  param_reg #(.RESET_VAL(PARAM_RESET)) u_first_param (
    .clk     (CLK),
    .rst_b   (RST_B),
    .host_we (p1_we),
    .host_d  (wd),
    .load    (p1_load),
    .load_d  (p1_val),
    .q       (p1)
  );

  param_reg #(.RESET_VAL(PARAM_RESET)) u_second_param (
    .clk     (CLK),
    .rst_b   (RST_B),
    .host_we (p2_we),
    .host_d  (wd),
    .load    (p2_load),
    .load_d  (p2_val),
    .q       (p2)
  );

  always_comb begin
    next_state       = state;
    next_cmd         = cmd;
    next_err         = err;
    next_shm_en      = shm_en;
    next_shm_base    = shm_base;
    next_shm_blocks  = shm_blocks;
    next_eng_req     = eng_req;
    next_eng_req.start = 1'b0;
    next_upper_clear = 1'b0;
    p1_load          = 1'b0;
    p1_val           = p1;
    p2_load          = 1'b0;
    p2_val           = p2;
    set_cmd_err      = 1'b0;
    set_dma          = 1'b0;
    if (ERR_CLEAR) begin
      next_err = ERR_RESET;
    end
    unique case (state)
      ST_IDLE: begin
        if (host_cmd_wr) begin
          next_cmd = CMD_RESET;
          if (!sel_one) begin
            set_cmd_err = 1'b1;
          end else if (wd[BIT_TEST]) begin
            // Stored cleaned so unused bits read zero
            next_cmd = {1'b1, 4'h0, wd[SEL_W-1:0]};
            p1_load  = 1'b1;
            p1_val   = PARAM_RESET;
            next_eng_req = '{start: 1'b1, kind: ENG_TEST,
                             sel: wd[SEL_W-1:0], arg_a: p1,
                             arg_b: p2};
            next_state = ST_EXEC;
          end else if (wd[BIT_IDENTIFY]) begin
            p1_load = 1'b1;
            p1_val  = BOARD_ID;
          end else if (wd[BIT_SHM_OFF]) begin
            if (shm_en) begin
              next_shm_en = 1'b0;
            end else begin
              set_cmd_err = 1'b1;
            end
          end else if (wd[BIT_SHM_SHOW]) begin
            if (shm_en) begin
              p1_load = 1'b1;
              p1_val  = 16'(shm_base);
              p2_load = 1'b1;
              p2_val  = shm_blocks;
            end else begin
              set_cmd_err = 1'b1;
            end
          end else if (wd[BIT_SHM_ON]) begin
            next_shm_en     = 1'b1;
            next_shm_base   = p2[SHM_BASE_W-1:0];
            next_shm_blocks = p1;
          end else if (wd[BIT_CONFIG]) begin
            p2_load = 1'b1;
            p2_val  = (16'(BOOT_SWITCH) << CFG_SWITCH_LSB)
                    | (16'(ROM_SIZE) << CFG_ROM_LSB);
          end else if (wd[BIT_DEBUG]) begin
            next_cmd   = wd;
            next_state = ST_DEBUG;
          end else if (wd[BIT_RESTART]) begin
            if (p2 > RESTART_USE_SWITCH) begin
              set_cmd_err = 1'b1;
            end else begin
              next_cmd = wd;
              next_eng_req = '{start: 1'b1, kind: ENG_RESTART,
                               sel: wd[SEL_W-1:0], arg_a: p1,
                               arg_b: (p2 == RESTART_USE_SWITCH) ?
                                 16'(BOOT_SWITCH) : p2};
              next_state = ST_EXEC;
            end
          end else if (wd[BIT_DMA] || wd[BIT_TRAP]) begin
            next_cmd = wd;
            // Offset tag or PC in arg_a, segment tag or PSW in arg_b
            next_eng_req = '{start: 1'b1,
                             kind: wd[BIT_DMA] ? ENG_DMA : ENG_TRAP,
                             sel: wd[SEL_W-1:0], arg_a: p1,
                             arg_b: p2};
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        // Host command writes are ignored here, except hard reset
        if (ENG_DONE) begin
          next_cmd   = CMD_RESET;
          next_state = ST_IDLE;
          if (eng_req.kind == ENG_TEST) begin
            if (ENG_FAIL) begin
              p1_load = 1'b1;
              p1_val  = p1 | 16'(eng_req.sel);
            end
            next_upper_clear = eng_req.sel[SEL_W-1];
          end else if (eng_req.kind == ENG_DMA) begin
            set_dma = 1'b1;
            p1_load = 1'b1;
            p1_val  = ENG_DATA;
          end else begin
            set_cmd_err = ENG_FAIL;
          end
        end
      end
      ST_DEBUG: begin
        if (host_cmd_wr) begin
          if (wd[DBG_EXIT] || wd[DBG_PROCEED] || wd[DBG_GO]) begin
            next_cmd   = CMD_RESET;
            next_state = ST_IDLE;
          end else begin
            next_cmd = wd;
          end
        end
      end
    endcase
    // Set wins over a same-cycle ERR_CLEAR; a hard reset below still clears both bits
    if (set_cmd_err) begin
      next_err[ERR_CMD] = 1'b1;
    end
    if (set_dma) begin
      next_err[ERR_DMA] = 1'b1;
    end
    if (hard_reset) begin
      next_state      = ST_IDLE;
      next_cmd        = CMD_RESET;
      next_err        = ERR_RESET;
      next_shm_en     = 1'b0;
      next_shm_base   = '0;
      next_shm_blocks = PARAM_RESET;
      next_eng_req    = '0;
      next_upper_clear = 1'b0;
      p1_load = 1'b1;
      p1_val  = PARAM_RESET;
      p2_load = 1'b1;
      p2_val  = 16'(BOOT_SWITCH) << CFG_SWITCH_LSB;
    end
    next_rdata = rdata;
    if (HOST_REQ.rd) begin
      unique case (HOST_REQ.addr)
        ADDR_CMD: next_rdata = cmd;
        ADDR_ERR: next_rdata = err;
        ADDR_P1:  next_rdata = p1;
        ADDR_P2:  next_rdata = p2;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state       <= ST_IDLE;
      cmd         <= CMD_RESET;
      err         <= ERR_RESET;
      shm_en      <= 1'b0;
      shm_base    <= '0;
      shm_blocks  <= PARAM_RESET;
      eng_req     <= '0;
      rdata       <= 16'h0000;
      upper_clear <= 1'b0;
    end else begin
      state       <= next_state;
      cmd         <= next_cmd;
      err         <= next_err;
      shm_en      <= next_shm_en;
      shm_base    <= next_shm_base;
      shm_blocks  <= next_shm_blocks;
      eng_req     <= next_eng_req;
      rdata       <= next_rdata;
      upper_clear <= next_upper_clear;
    end
  end

  assign HOST_RDATA    = rdata;
  assign LOCAL_POWERUP = hard_reset;
  assign ENG_REQ       = eng_req;
  assign SHM_ENABLE    = shm_en;
  assign SHM_BASE      = shm_base;
  assign SHM_BLOCKS    = shm_blocks;
  assign DEBUG_MODE    = (state == ST_DEBUG);
  assign UPPER_CLEAR   = upper_clear;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  logic idle_wr;
  assign idle_wr = (state == ST_IDLE) && host_cmd_wr && !wd[BIT_HARD_RESET];

  AST_HARD_RESET_POWERUP: assert property (
    hard_reset |-> LOCAL_POWERUP ##1 (cmd == CMD_RESET && !ENG_REQ.start))
    else $error("hard reset did not restart the port");
  AST_HARD_RESET_ANY_STATE: assert property (
    hard_reset |=> (state == ST_IDLE && err == ERR_RESET && p1 == 16'h0000))
    else $error("hard reset left state behind");
  AST_IDENTIFY: assert property (
    idle_wr && wd == 16'h0400 |=> p1 == BOARD_ID && cmd == CMD_RESET)
    else $error("identify command gave wrong value");
  AST_SHM_OFF_ERR: assert property (
    idle_wr && wd == 16'h0100 && !shm_en |=> err[ERR_CMD])
    else $error("disable while disabled not flagged");
  AST_SHM_ON: assert property (
    idle_wr && wd == 16'h0040 |=> shm_en && shm_blocks == $past(p1))
    else $error("enable shared memory wrong");
  AST_DEBUG: assert property (
    idle_wr && wd == 16'h0008 |=> DEBUG_MODE && cmd == 16'h0008)
    else $error("debug mode not entered");
  AST_RESTART_BAD: assert property (
    idle_wr && wd == 16'h0004 && p2 > 16'h0008
      |=> err[ERR_CMD] && !ENG_REQ.start)
    else $error("invalid restart value accepted");
  AST_TEST_DONE: assert property (
    state == ST_EXEC && ENG_DONE && !hard_reset |=> cmd == CMD_RESET)
    else $error("command register not cleared at completion");
  AST_TEST_ZERO: assert property (
    state == ST_EXEC && cmd[BIT_TEST] |-> cmd[14:11] == 4'h0)
    else $error("unused test bits not zero");
  AST_MULTI: assert property (
    idle_wr && !sel_one |=> err[ERR_CMD] && cmd == CMD_RESET && !ENG_REQ.start)
    else $error("multi-bit command not refused");

  COV_TEST: cover property (
    idle_wr && wd[BIT_TEST] && sel_one ##[1:50] ENG_DONE);
  COV_DMA: cover property (
    state == ST_EXEC && ENG_REQ.kind == ENG_DMA && ENG_DONE);
  COV_HARD_RESET_BUSY: cover property (state == ST_EXEC && hard_reset);

endmodule // host_command_test_port

//--- dv/eng_model.sv
// Behavioural operation engine facing the command port
`timescale 1ns/10ps
module eng_model
  import hcp_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Request side
  input  wire eng_req_t    req,
  input  wire logic        abort,
  // Scenario controls
  input  wire logic [7:0]  delay,
  input  wire logic        fail,
  input  wire logic [15:0] status,
  // Answer
  output logic             done,
  output logic             fail_o,
  output logic [15:0]      data
);
  int          cnt = -1;
  logic [15:0] junk = 16'h5a5a;

  // Outside the done pulse the answer lines churn, so stale data shows
  always @(posedge clk) begin
    junk   <= ~junk;
    done   <= 1'b0;
    fail_o <= junk[0];
    data   <= junk;
    if (abort) begin
      cnt <= -1;
    end else if (req.start) begin
      cnt <= int'(delay);
    end else if (cnt == 0) begin
      done   <= 1'b1;
      fail_o <= fail;
      data   <= status;
      cnt    <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // eng_model

//--- dv/tb_host_command_test_port.sv
// Self-checking bench for the host command and test port
`timescale 1ns/10ps
module tb_host_command_test_port
  import hcp_pkg::*;
;
  localparam logic [15:0] ID = 16'h00a5;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  host_req_t host_req = '0;
  logic [15:0] rdata, eng_data, shm_blocks, sts = 16'hbeef;
  logic powerup, eng_done, eng_fail, shm_en, debug_mode, upper_clear;
  logic [3:0] boot_sw = 4'ha;
  logic [1:0] rom_size = 2'b10;
  logic err_clear = 1'b0;
  logic fail = 1'b0;
  logic pu;
  logic [7:0] dly = 8'd5;
  logic [SHM_BASE_W-1:0] shm_base;
  eng_req_t eng_req, last;
  int failures = 0;
  int compares = 0;
  int starts = 0;
  int uclr = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  host_command_test_port #(.BOARD_ID(ID)) u_dut (
    .CLK(clk), .RST_B(rst_b), .HOST_REQ(host_req), .HOST_RDATA(rdata),
    .LOCAL_POWERUP(powerup), .BOOT_SWITCH(boot_sw), .ROM_SIZE(rom_size),
    .ENG_REQ(eng_req), .ENG_DONE(eng_done), .ENG_FAIL(eng_fail),
    .ENG_DATA(eng_data), .ERR_CLEAR(err_clear), .SHM_ENABLE(shm_en),
    .SHM_BASE(shm_base), .SHM_BLOCKS(shm_blocks),
    .DEBUG_MODE(debug_mode), .UPPER_CLEAR(upper_clear));

  eng_model u_eng (
    .clk(clk), .req(eng_req), .abort(powerup), .delay(dly), .fail(fail),
    .status(sts), .done(eng_done), .fail_o(eng_fail), .data(eng_data));

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far above the longest sequence
  always @(posedge clk) begin
    cycles++;
    if (eng_req.start) begin
      starts++;
      last <= eng_req;
    end
    if (upper_clear)
      uclr++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask

  // Each access starts on a fresh falling edge, so no double drive
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge clk);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    #5 pu = powerup;
    @(negedge clk);
    host_req = '0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(negedge clk);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    @(negedge clk);
    host_req = '0;
    v = rdata;
  endtask

  task automatic rc(input logic [1:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk($sformatf("reg%0d", a), e, v);
  endtask

  task automatic clr_err();
    @(negedge clk);
    err_clear = 1'b1;
    @(negedge clk);
    err_clear = 1'b0;
    rc(ADDR_ERR, 16'h0);
  endtask

  task automatic wait_idle();
    logic [15:0] v;
    int n;
    n = 0;
    do begin
      rd(ADDR_CMD, v);
      n++;
    end while (v !== 16'h0 && n < 60);
    chk("idle", 16'h0, v);
  endtask

  task automatic t_reset();
    int a;
    for (a = 0; a < 4; a++)
      rc(2'(a), 16'h0);
    wr(ADDR_ERR, 16'hffff);
    rc(ADDR_ERR, 16'h0);
  endtask

  task automatic t_identify();
    wr(ADDR_CMD, 16'h0400);
    chk("pu", 16'h0, {15'h0, pu});
    rc(ADDR_P1, ID);
    rc(ADDR_CMD, 16'h0);
  endtask

  task automatic t_shm();
    wr(ADDR_CMD, 16'h0100);
    rc(ADDR_ERR, 16'h8000);
    clr_err();
    wr(ADDR_CMD, 16'h0080);
    rc(ADDR_ERR, 16'h8000);
    clr_err();
    wr(ADDR_P1, 16'h0012);
    wr(ADDR_P2, 16'h02a7);
    wr(ADDR_CMD, 16'h0040);
    chk("en", 16'h1, {15'h0, shm_en});
    chk("base", 16'h02a7, {6'h0, shm_base});
    chk("blocks", 16'h0012, shm_blocks);
    wr(ADDR_P1, 16'h0);
    wr(ADDR_CMD, 16'h0080);
    rc(ADDR_P1, 16'h02a7);
    rc(ADDR_P2, 16'h0012);
    wr(ADDR_CMD, 16'h0100);
    chk("off", 16'h0, {15'h0, shm_en});
    rc(ADDR_ERR, 16'h0);
  endtask

  task automatic t_config();
    wr(ADDR_CMD, 16'h0010);
    rc(ADDR_P2, {8'h0, boot_sw, 4'h4});
  endtask

  task automatic t_tests();
    int i;
    int s;
    logic [15:0] b;
    s = starts;
    for (i = 0; i < SEL_W; i++) begin
      b = 16'h1 << i;
      fail = i[0];
      wr(ADDR_P1, 16'hffff);
      wr(ADDR_P2, 16'(i));
      wr(ADDR_CMD, 16'h8800 | b);
      rc(ADDR_CMD, 16'h8000 | b);
      chk("kind", 16'(ENG_TEST), 16'(last.kind));
      chk("sel", b, {5'h0, last.sel});
      chk("targ", 16'(i), last.arg_b);
      wait_idle();
      rc(ADDR_P1, fail ? b : 16'h0);
    end
    chk("starts", 16'(s + SEL_W), 16'(starts));
    chk("uclr", 16'h1, 16'(uclr));
  endtask

  task automatic t_bad();
    int s;
    s = starts;
    wr(ADDR_CMD, 16'h8003);
    rc(ADDR_CMD, 16'h0);
    rc(ADDR_ERR, 16'h8000);
    clr_err();
    wr(ADDR_CMD, 16'h0003);
    rc(ADDR_ERR, 16'h8000);
    clr_err();
    chk("nostart", 16'(s), 16'(starts));
  endtask

  task automatic t_dma_trap();
    fail = 1'b0;
    wr(ADDR_P1, 16'h1234);
    wr(ADDR_P2, 16'h0056);
    wr(ADDR_CMD, 16'h0002);
    // Start pulse is captured one edge after the write lands
    @(negedge clk);
    chk("dkind", 16'(ENG_DMA), 16'(last.kind));
    chk("seg", 16'h0056, last.arg_b);
    chk("off", 16'h1234, last.arg_a);
    wait_idle();
    rc(ADDR_ERR, 16'h4000);
    rc(ADDR_P1, 16'hbeef);
    clr_err();
    fail = 1'b1;
    wr(ADDR_P1, 16'h0200);
    wr(ADDR_P2, 16'h00e0);
    wr(ADDR_CMD, 16'h0001);
    @(negedge clk);
    chk("tkind", 16'(ENG_TRAP), 16'(last.kind));
    chk("pc", 16'h0200, last.arg_a);
    chk("ps", 16'h00e0, last.arg_b);
    wait_idle();
    rc(ADDR_ERR, 16'h8000);
    clr_err();
    fail = 1'b0;
  endtask

  task automatic t_restart();
    int s;
    wr(ADDR_P2, 16'h0008);
    wr(ADDR_CMD, 16'h0004);
    @(negedge clk);
    chk("rkind", 16'(ENG_RESTART), 16'(last.kind));
    chk("rsw", {12'h0, boot_sw}, last.arg_b);
    wait_idle();
    wr(ADDR_P2, 16'h0007);
    wr(ADDR_CMD, 16'h0004);
    @(negedge clk);
    chk("rval", 16'h0007, last.arg_b);
    wait_idle();
    s = starts;
    wr(ADDR_P2, 16'h0009);
    wr(ADDR_CMD, 16'h0004);
    rc(ADDR_ERR, 16'h8000);
    chk("rnone", 16'(s), 16'(starts));
    clr_err();
  endtask

  task automatic t_debug();
    logic [15:0] ex [3];
    int i;
    ex = '{16'h8000, 16'h0010, 16'h0008};
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CMD, 16'h0008);
      chk("dbg", 16'h1, {15'h0, debug_mode});
      wr(ADDR_CMD, 16'h0220);
      rc(ADDR_CMD, 16'h0220);
      wr(ADDR_CMD, ex[i]);
      chk("dbgx", 16'h0, {15'h0, debug_mode});
      rc(ADDR_CMD, 16'h0);
    end
  endtask

  task automatic t_hard();
    wr(ADDR_P1, 16'h0003);
    wr(ADDR_CMD, 16'h0040);
    wr(ADDR_CMD, 16'h0008);
    wr(ADDR_CMD, 16'h4000);
    chk("dbghr", 16'h0, {15'h0, debug_mode});
    chk("shmhr", 16'h0, {15'h0, shm_en});
    dly = 8'd30;
    fail = 1'b1;
    wr(ADDR_CMD, 16'h8004);
    wr(ADDR_CMD, 16'h4000);
    chk("pu", 16'h1, {15'h0, pu});
    rc(ADDR_CMD, 16'h0);
    rc(ADDR_P2, {8'h0, boot_sw, 4'h0});
    rc(ADDR_ERR, 16'h0);
    repeat (40) @(negedge clk);
    rc(ADDR_P1, 16'h0);
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_identify();
    t_shm();
    t_config();
    t_tests();
    t_bad();
    t_dma_trap();
    t_restart();
    t_debug();
    t_hard();
    give_verdict();
  end
endmodule // tb_host_command_test_port
